// ===== rtl/pmw_power_ctl.v
// power mode, wakeup and interrupt front-end controller with an axi4-lite slave
`timescale 1ns/10ps
`include "pmw_regs.vh"
module pmw_power_ctl #(
	parameter SETTLE_CYCLES = ((`PMW_SETTLE_HCLK * 64'd100) + 64'd5) / 64'd6
		+ (`PMW_STARTUP_NS + 9) / 10
) (
	input wire aclk,
	input wire aresetn,
	input wire [9:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [9:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire port_wake_event,
	input wire external_pin_irq,
	input wire timer_overflow,
	input wire usb_bus_toggle,
	input wire usb_done,
	input wire irq_ack,
	input wire return_from_irq_instr,
	output reg cpu_run,
	output reg cpu_tick,
	output reg fast_osc_on,
	output reg slow_osc_on,
	output reg sys_clk_slow,
	output reg irq_take,
	output reg [15:0] irq_vector,
	output reg [2:0] stack_pointer_reg
);
	// sequencer states; settle sits between sleep and run
	localparam ST_RUN = 3'h0;
	localparam ST_SLEEP = 3'h1;
	localparam ST_GREEN = 3'h2;
	localparam ST_SETTLE = 3'h3;
	localparam ST_PRE = 3'h4;

	// software visible state, plus the internal settle counter
	reg [7:0] interrupt_enable_mask;
	reg [7:0] interrupt_request_flags;
	reg [7:0] oscillator_mode_reg;
	reg global_irq_enable;
	reg timer_wake_enable;
	reg in_service;
	reg [2:0] state;
	reg [31:0] settle_count;
	// write channel capture: index, data and strobes wait here until both halves arrive
	reg aw_held, w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire slow_tick;
	// fields of the oscillator mode register
	wire [1:0] cpu_mode_select = oscillator_mode_reg[`PMW_BIT_CPUM_HI:`PMW_BIT_CPUM_LO];
	wire slow_clock_select = oscillator_mode_reg[`PMW_BIT_SLOW];
	wire high_osc_halt = oscillator_mode_reg[`PMW_BIT_HALT];
	// one strobe per writable register word; only the low byte lane carries data
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire wr_flags = do_write && aw_addr == `PMW_OFF_IRQ_FLAGS && w_strb[0];
	wire wr_en = do_write && aw_addr == `PMW_OFF_IRQ_EN && w_strb[0];
	wire wr_osc = do_write && aw_addr == `PMW_OFF_OSC_MODE && w_strb[0];
	wire wr_glob = do_write && aw_addr == `PMW_OFF_GLOBAL && w_strb[0];
	wire wr_ctl = do_write && aw_addr == `PMW_OFF_CPU_CTL && w_strb[0];
	// every mapped word answers okay, even when its write is ignored
	wire addr_ok_w = aw_addr == `PMW_OFF_IRQ_FLAGS || aw_addr == `PMW_OFF_IRQ_EN
		|| aw_addr == `PMW_OFF_OSC_MODE || aw_addr == `PMW_OFF_GLOBAL
		|| aw_addr == `PMW_OFF_CPU_CTL || aw_addr == `PMW_OFF_STATUS;
	// a request counts only when flagged and enabled; the odd bit positions do not exist
	wire [7:0] pending = interrupt_request_flags & interrupt_enable_mask & `PMW_IRQ_MASK;
	// wake sources per mode; reserved code leaves sleep and green unreachable
	wire sleep_wake = port_wake_event || external_pin_irq || usb_bus_toggle;
	wire green_wake = port_wake_event || external_pin_irq || usb_bus_toggle
		|| (timer_wake_enable && timer_overflow);
	// interrupts are taken only while executing and outside a service routine
	wire executing = (state == ST_RUN);
	wire take = executing && global_irq_enable && !in_service && (pending != 8'h00);
	// next values of the flag register, the sequencer and the read word
	reg [7:0] next_flags;
	reg [2:0] next_state;
	reg [31:0] next_rdata;
	reg [1:0] next_rresp;

	// slow mode instruction rate comes from a divide-by-four enable
	pmw_divider #(
		.DIV(`PMW_SLOW_DIV)
	) u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(executing && slow_clock_select),
		.tick(slow_tick)
	);

	// request flags: hardware set wins over a software clear in the same cycle
	always @*
	begin
		next_flags = interrupt_request_flags;
		if (wr_flags)
			next_flags = w_data[7:0] & `PMW_IRQ_MASK;
		if (external_pin_irq)
			next_flags[`PMW_BIT_PIN] = 1'b1;
		if (port_wake_event)
			next_flags[`PMW_BIT_WAKE] = 1'b1;
		if (timer_overflow)
			next_flags[`PMW_BIT_TIMER] = 1'b1;
		if (usb_done)
			next_flags[`PMW_BIT_USB] = 1'b1;
	end

	// mode sequencer
	always @*
	begin
		next_state = state;
		case (state)
			ST_RUN:
				if (cpu_mode_select == `PMW_CPUM_SLEEP)
					next_state = ST_SLEEP;
				else if (cpu_mode_select == `PMW_CPUM_GREEN)
					next_state = ST_GREEN;
			ST_SLEEP:
				if (sleep_wake)
					next_state = ST_SETTLE;
			ST_SETTLE:
				if (settle_count >= SETTLE_CYCLES - 1)
					next_state = ST_RUN;
			ST_GREEN:
				if (green_wake)
					next_state = ST_RUN;
			default:
				next_state = ST_RUN;
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= ST_RUN;
			settle_count <= 32'h0;
			interrupt_request_flags <= `PMW_RESET_VALUE;
			interrupt_enable_mask <= `PMW_RESET_VALUE;
			oscillator_mode_reg <= `PMW_RESET_VALUE;
			global_irq_enable <= 1'b0;
			timer_wake_enable <= 1'b0;
			in_service <= 1'b0;
			stack_pointer_reg <= `PMW_STACK_POINTER_REG_RESET;
		end
		else
		begin
			state <= next_state;
			interrupt_request_flags <= next_flags;
			// settle counter runs only in the settle state and parks at zero elsewhere
			settle_count <= (state == ST_SETTLE) ? settle_count + 32'h1 : 32'h0;
			if (wr_en)
				interrupt_enable_mask <= w_data[7:0] & `PMW_IRQ_MASK;
			if (wr_ctl)
				timer_wake_enable <= w_data[0];
			// mode bits return to normal on wakeup; sleep always leaves slow mode
			if (state == ST_SETTLE && next_state == ST_RUN)
				oscillator_mode_reg <= oscillator_mode_reg
					& ~(8'h18 | (8'h01 << `PMW_BIT_SLOW));
			else if (state == ST_GREEN && next_state == ST_RUN)
				oscillator_mode_reg <= oscillator_mode_reg & ~8'h18;
			else if (wr_osc && executing)
				oscillator_mode_reg <= w_data[7:0] & `PMW_OSC_MASK;
			// global enable: hardware entry and exit win over a software write
			if (take)
			begin
				global_irq_enable <= 1'b0;
				in_service <= 1'b1;
				stack_pointer_reg <= stack_pointer_reg - 3'h1;
			end
			else if (in_service && return_from_irq_instr)
			begin
				global_irq_enable <= 1'b1;
				in_service <= 1'b0;
				stack_pointer_reg <= stack_pointer_reg + 3'h1;
			end
			else if (wr_glob)
			begin
				global_irq_enable <= w_data[`PMW_BIT_GIE];
				stack_pointer_reg <= w_data[2:0];
			end
		end
	end

	// cpu facing outputs, registered; irq_take holds until the core acknowledges
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cpu_run <= 1'b1;
			cpu_tick <= 1'b0;
			fast_osc_on <= 1'b1;
			slow_osc_on <= 1'b1;
			sys_clk_slow <= 1'b0;
			irq_take <= 1'b0;
			irq_vector <= 16'h0000;
		end
		else
		begin
			cpu_run <= (next_state == ST_RUN);
			cpu_tick <= (next_state == ST_RUN) && (!slow_clock_select || slow_tick);
			fast_osc_on <= !(next_state == ST_SLEEP) && !high_osc_halt;
			slow_osc_on <= !(next_state == ST_SLEEP);
			sys_clk_slow <= slow_clock_select;
			if (take)
			begin
				irq_take <= 1'b1;
				irq_vector <= `PMW_VECTOR;
			end
			else if (irq_ack)
				irq_take <= 1'b0;
		end
	end

	// axi write channels: address and data accepted in either order
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PMW_RESP_OKAY;
		end
		else
		begin
			// ready stays low from each take until the response is accepted, so a second beat never slips in
			s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr[9:2]; // word index; the byte lane bits are ignored
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_ok_w ? `PMW_RESP_OKAY : `PMW_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// read decode kept apart from the handshake; unmapped words read zero with slverr
	always @*
	begin
		next_rdata = 32'h0;
		next_rresp = `PMW_RESP_OKAY;
		case (s_axi_araddr[9:2])
			`PMW_OFF_IRQ_FLAGS: next_rdata = {24'h0, interrupt_request_flags};
			`PMW_OFF_IRQ_EN: next_rdata = {24'h0, interrupt_enable_mask};
			`PMW_OFF_OSC_MODE: next_rdata = {24'h0, oscillator_mode_reg};
			`PMW_OFF_GLOBAL: next_rdata = {24'h0, global_irq_enable, 4'h0,
				stack_pointer_reg};
			`PMW_OFF_CPU_CTL: next_rdata = {31'h0, timer_wake_enable};
			`PMW_OFF_STATUS: next_rdata = {28'h0, in_service, state};
			default:
				next_rresp = `PMW_RESP_SLVERR;
		endcase
	end

	// axi read channel: one read at a time, unmapped answers slverr with zero
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `PMW_RESP_OKAY;
		end
		else
		begin
			// ready pulses while idle; the decode is sampled at the address take
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rresp;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // pmw_power_ctl

// ===== rtl/pmw_regs.vh
// register offsets, field positions, reset values and timing counts for the power mode controller
`ifndef PMW_REGS_VH
`define PMW_REGS_VH
// register word indices; the bus byte address is four times the index
`define PMW_OFF_IRQ_FLAGS 8'hC8
`define PMW_OFF_IRQ_EN 8'hC9
`define PMW_OFF_OSC_MODE 8'hCA
`define PMW_OFF_GLOBAL 8'hDF
`define PMW_OFF_CPU_CTL 8'hE0
`define PMW_OFF_STATUS 8'hE4
// interrupt enable and request bit positions
`define PMW_BIT_PIN 0
`define PMW_BIT_WAKE 2
`define PMW_BIT_TIMER 4
`define PMW_BIT_USB 6
`define PMW_IRQ_MASK 8'h55
// oscillator mode register fields
`define PMW_BIT_HALT 1
`define PMW_BIT_SLOW 2
`define PMW_BIT_CPUM_LO 3
`define PMW_BIT_CPUM_HI 4
`define PMW_OSC_MASK 8'h1E
// cpu mode codes
`define PMW_CPUM_NORMAL 2'h0
`define PMW_CPUM_SLEEP 2'h1
`define PMW_CPUM_GREEN 2'h2
`define PMW_CPUM_RSVD 2'h3
// global enable and stack pointer
`define PMW_BIT_GIE 7
`define PMW_STACK_POINTER_REG_RESET 3'h7
`define PMW_VECTOR 16'h0008
`define PMW_RESET_VALUE 8'h00
// wakeup settle: 2048 high clock periods plus start-up, high clock 6 MHz
`define PMW_SETTLE_HCLK 2048
`define PMW_HCLK_HZ 6000000
`define PMW_SYS_HZ 100000000
`define PMW_STARTUP_NS 100000
`define PMW_SLOW_DIV 4
// axi responses
`define PMW_RESP_OKAY 2'h0
`define PMW_RESP_SLVERR 2'h2
`endif

// ===== rtl/pmw_divider.v
// divide-by-N enable generator for the slow instruction cycle
`timescale 1ns/10ps
module pmw_divider #(
	parameter DIV = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire run,
	output reg tick
);
	reg [7:0] count;
	// one tick every DIV clocks while running, counter parked otherwise
	always @(posedge aclk)
	begin
		if (!aresetn || !run)
		begin
			count <= 8'h00;
			tick <= 1'b0;
		end
		else if (count == DIV[7:0] - 8'h01)
		begin
			count <= 8'h00;
			tick <= 1'b1;
		end
		else
		begin
			count <= count + 8'h01;
			tick <= 1'b0;
		end
	end
endmodule // pmw_divider

// ===== tb/pmw_power_ctl_props.sv
// port assertions for the power mode controller
`timescale 1ns/10ps
module pmw_power_ctl_props (
	input wire aclk,
	input wire aresetn,
	input wire irq_ack,
	input wire return_from_irq_instr,
	input wire cpu_run,
	input wire cpu_tick,
	input wire fast_osc_on,
	input wire slow_osc_on,
	input wire sys_clk_slow,
	input wire irq_take,
	input wire [15:0] irq_vector,
	input wire [2:0] stack_pointer_reg
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_tick_in_run: assert property (cpu_tick |-> cpu_run)
		else $error("tick while halted");
	a_sleep_all_off: assert property (!slow_osc_on |-> !fast_osc_on && !cpu_run)
		else $error("sleep left a clock or execution on");
	// the simulated settle count is 20, so eight idle cycles is a safe floor
	a_settle_wait: assert property ($rose(slow_osc_on) |-> !cpu_run [*8])
		else $error("ran before settling");
	a_take_vector: assert property ($rose(irq_take) |-> irq_vector == 16'h0008)
		else $error("wrong vector");
	a_take_push: assert property ($rose(irq_take) |-> stack_pointer_reg == $past(stack_pointer_reg) - 3'h1)
		else $error("no push on take");
	a_return_pop: assert property (return_from_irq_instr |=> stack_pointer_reg == $past(stack_pointer_reg) + 3'h1)
		else $error("no pop on return");
	a_take_holds: assert property (irq_take && !irq_ack |=> irq_take)
		else $error("take dropped before ack");
	a_slow_gap: assert property (cpu_tick && sys_clk_slow |=> (!cpu_tick || !sys_clk_slow) [*3])
		else $error("slow tick too often");
endmodule // pmw_power_ctl_props

// ===== tb/pmw_core_model.sv
// cpu core stand-in: acknowledges a taken interrupt at its vector fetch
`timescale 1ns/10ps
module pmw_core_model (
	input wire aclk,
	input wire aresetn,
	input wire irq_take,
	output reg irq_ack
);
	// one cycle late, so the take level must hold for the core to see it
	always @(posedge aclk)
	begin
		if (!aresetn)
			irq_ack <= 1'b0;
		else
			irq_ack <= irq_take & ~irq_ack;
	end
endmodule // pmw_core_model

// ===== tb/test_pmw_power_ctl.sv
// directed bench for the power mode controller
`timescale 1ns/10ps
`include "pmw_regs.vh"
module test_pmw_power_ctl;
	reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	reg [9:0] awaddr, araddr;
	reg [31:0] wdata, rd_data;
	reg [1:0] rd_resp, wr_resp;
	reg [5:0] ev;
	wire awready, wready, bvalid, arready, rvalid, irq_ack, cpu_run, cpu_tick;
	wire fast_osc_on, slow_osc_on, sys_clk_slow, irq_take;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] irq_vector;
	wire [2:0] stack_pointer_reg;
	integer err_total, checked, cyc, n, i;
	pmw_power_ctl #(.SETTLE_CYCLES(20)) uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.port_wake_event(ev[0]), .external_pin_irq(ev[1]), .timer_overflow(ev[2]),
		.usb_bus_toggle(ev[3]), .usb_done(ev[4]), .irq_ack(irq_ack),
		.return_from_irq_instr(ev[5]), .cpu_run(cpu_run), .cpu_tick(cpu_tick),
		.fast_osc_on(fast_osc_on), .slow_osc_on(slow_osc_on), .sys_clk_slow(sys_clk_slow),
		.irq_take(irq_take), .irq_vector(irq_vector), .stack_pointer_reg(stack_pointer_reg));
	pmw_core_model core (.aclk(aclk), .aresetn(aresetn), .irq_take(irq_take), .irq_ack(irq_ack));
	task tally_and_finish;
	begin
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
	begin
		checked = checked + 1;
		if (g !== e)
		begin
			err_total = err_total + 1;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task tk(input integer k);
		repeat (k) @(posedge aclk);
	endtask
	// each channel is released at the edge that takes it; a is the word index
	// bready and rready stay high between transfers, so no edge sees them toggle twice
	task wr(input [7:0] a, input [31:0] d);
	begin
		awaddr <= {a, 2'h0};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		wr_resp = bresp;
	end
	endtask
	task rd(input [7:0] a);
	begin
		araddr <= {a, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd_data = rdata;
		rd_resp = rresp;
	end
	endtask
	task pulse(input integer k);
	begin
		ev[k] <= 1'b1;
		@(posedge aclk);
		ev[k] <= 1'b0;
		@(posedge aclk);
	end
	endtask
	// counts cycles until execution resumes, bounded
	task wait_run;
	begin
		n = 0;
		while (cpu_run !== 1'b1 && n < 100)
		begin
			@(posedge aclk);
			n = n + 1;
		end
	end
	endtask
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// hang guard: the sequence needs well under 2000 cycles
	always @(posedge aclk)
	begin
		cyc = cyc + 1;
		if (cyc == 5000)
		begin
			err_total = err_total + 1;
			tally_and_finish;
		end
	end
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, ev} = 58'h0;
		err_total = 0;
		checked = 0;
		cyc = 0;
		tk(3);
		aresetn <= 1'b1;
		tk(1);
		chk("sp_reset", 3'h7, stack_pointer_reg);
		rd(`PMW_OFF_IRQ_EN);
		chk("enable_reset", 32'h0, rd_data);
		rd(8'h00);
		chk("unmapped_resp", `PMW_RESP_SLVERR, rd_resp);
		wr(8'h00, 32'h0);
		chk("unmapped_wr_resp", `PMW_RESP_SLVERR, wr_resp);
		// flag is set with its enable off, and nothing is taken
		wr(`PMW_OFF_GLOBAL, 32'h87);
		chk("write_resp", `PMW_RESP_OKAY, wr_resp);
		pulse(1);
		tk(3);
		chk("take_masked", 1'b0, irq_take);
		rd(`PMW_OFF_IRQ_FLAGS);
		chk("flag_pin", 32'h1, rd_data);
		wr(`PMW_OFF_IRQ_EN, 32'hFF);
		n = 0;
		while (irq_take !== 1'b1 && n < 20)
		begin
			tk(1);
			n = n + 1;
		end
		chk("take", 1'b1, irq_take);
		chk("vector", 16'h0008, irq_vector);
		chk("sp_push", 3'h6, stack_pointer_reg);
		rd(`PMW_OFF_GLOBAL);
		chk("gie_cleared", 32'h06, rd_data);
		wr(`PMW_OFF_IRQ_FLAGS, 32'h0);
		pulse(5);
		rd(`PMW_OFF_GLOBAL);
		chk("gie_restored", 32'h87, rd_data);
		rd(`PMW_OFF_IRQ_EN);
		chk("enable_bits", `PMW_IRQ_MASK, rd_data);
		wr(`PMW_OFF_IRQ_EN, 32'h0);
		pulse(4);
		rd(`PMW_OFF_IRQ_FLAGS);
		chk("flag_usb", 32'h40, rd_data);
		// green from normal: timer wake off, so the timer is ignored and a port wake event wakes
		wr(`PMW_OFF_OSC_MODE, 32'h10);
		tk(2);
		chk("green_halt", 1'b0, cpu_run);
		pulse(2);
		chk("green_timer_ignored", 1'b0, cpu_run);
		pulse(0);
		tk(1);
		chk("green_wake", 1'b1, cpu_run);
		wr(`PMW_OFF_OSC_MODE, 32'h04);
		tk(2);
		chk("slow_select", 1'b1, sys_clk_slow);
		n = 0;
		repeat (16)
		begin
			@(posedge aclk);
			if (cpu_tick === 1'b1) n = n + 1;
		end
		chk("slow_rate", 4, n);
		// green from slow with timer wake on returns to slow
		wr(`PMW_OFF_CPU_CTL, 32'h1);
		wr(`PMW_OFF_OSC_MODE, 32'h14);
		tk(2);
		chk("green_slow_halt", 1'b0, cpu_run);
		pulse(2);
		tk(1);
		chk("timer_wake", 1'b1, cpu_run);
		chk("back_to_slow", 1'b1, sys_clk_slow);
		// halt the fast oscillator in slow mode, then restart it and let it settle
		wr(`PMW_OFF_OSC_MODE, 32'h06);
		tk(2);
		chk("fast_halted", 1'b0, fast_osc_on);
		chk("slow_osc_kept", 1'b1, slow_osc_on);
		wr(`PMW_OFF_OSC_MODE, 32'h04);
		tk(64); // start-up wait before leaving slow mode, scaled down like the settle count
		chk("fast_restarted", 1'b1, fast_osc_on);
		wr(`PMW_OFF_OSC_MODE, 32'h18);
		tk(3);
		chk("reserved_runs", 1'b1, cpu_run);
		// sleep: the timer must not wake it; each outside source must
		for (i = 0; i < 4; i = i + 1)
		begin
			if (i != 2)
			begin
				wr(`PMW_OFF_OSC_MODE, 32'h08);
				tk(2);
				chk("sleep_fast_off", 1'b0, fast_osc_on);
				chk("sleep_slow_off", 1'b0, slow_osc_on);
				pulse(2);
				chk("sleep_timer_ignored", 1'b0, cpu_run);
				pulse(i);
				wait_run;
				chk("settle_window", 1'b1, n >= 18 && n <= 26);
				chk("wake_normal", 1'b0, sys_clk_slow);
			end
		end
		tally_and_finish;
	end
endmodule // test_pmw_power_ctl
bind pmw_power_ctl pmw_power_ctl_props u_props (.aclk(aclk), .aresetn(aresetn),
	.irq_ack(irq_ack), .return_from_irq_instr(return_from_irq_instr), .cpu_run(cpu_run),
	.cpu_tick(cpu_tick), .fast_osc_on(fast_osc_on), .slow_osc_on(slow_osc_on),
	.sys_clk_slow(sys_clk_slow), .irq_take(irq_take), .irq_vector(irq_vector),
	.stack_pointer_reg(stack_pointer_reg));
